// >>> ddmas_regs.vh
`ifndef DDMAS_REGS_VH
`define DDMAS_REGS_VH

// register offsets inside the 16-byte i/o window
`define DDMAS_OFS_PAGE      4'h2
`define DDMAS_OFS_COUNT_LO  4'h4
`define DDMAS_OFS_COUNT_HI  4'h5
`define DDMAS_OFS_STATCMD   4'h8
`define DDMAS_OFS_SWREQ     4'h9
`define DDMAS_OFS_MODE      4'hb
`define DDMAS_OFS_MCLEAR    4'hd
`define DDMAS_OFS_MASK      4'hf

// reset values
`define DDMAS_PAGE_RST      8'h00
`define DDMAS_COUNT_RST     16'h0000
`define DDMAS_MODE_RST      8'h00
`define DDMAS_MASK_RST      1'b1

// field positions
`define DDMAS_CMD_DIS_BIT   2
`define DDMAS_MODE_SEL_HI   7
`define DDMAS_MODE_SEL_LO   6
`define DDMAS_MODE_RW_MASK  6'h3c

// transfer mode select encodings
`define DDMAS_XMODE_DEMAND  2'b00
`define DDMAS_XMODE_SINGLE  2'b01
`define DDMAS_XMODE_BLOCK   2'b10

// count decrements per transfer
`define DDMAS_DEC_8BIT      16'h0001
`define DDMAS_DEC_16BIT     16'h0002

// misc constants
`define DDMAS_ZERO8         8'h00
`define DDMAS_ZERO16        16'h0000
`define DDMAS_NIBBLE_ONES   4'hf
`define DDMAS_NIBBLE_ZERO   4'h0

`endif

// >>> ddmas_flag.v
`timescale 1ns/100ps
// sticky flag: set wins over clear, cleared also by channel reset
module ddmas_flag (
	mclk,
	rst_b,
	set_i,
	clr_i,
	flag_q
);
	input  wire mclk;
	input  wire rst_b;
	input  wire set_i;
	input  wire clr_i;
	output reg  flag_q;

	// a set in the clearing cycle is kept so no terminal count is lost
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			flag_q <= 1'b0;
		end else if (set_i) begin
			flag_q <= 1'b1;
		end else if (clr_i) begin
			flag_q <= 1'b0;
		end
	end
endmodule // ddmas_flag

// >>> ddmas_core.v
`timescale 1ns/100ps
`include "ddmas_regs.vh"

module ddmas_core (
	mclk,
	rst_b,
	io_addr,
	io_wr,
	io_rd,
	io_wdata,
	io_rdata,
	card_transfer_request,
	xfer_done,
	xfer_16bit,
	chan_reset,
	svc_request_q,
	controller_enabled_q,
	addr_upper_q,
	terminal_count_q
);
	input  wire        mclk;
	input  wire        rst_b;
	input  wire [3:0]  io_addr;                // byte offset within the i/o window
	input  wire        io_wr;                  // one-cycle write strobe
	input  wire        io_rd;                  // one-cycle read strobe
	input  wire [7:0]  io_wdata;
	output reg  [7:0]  io_rdata;
	input  wire        card_transfer_request;  // card request level
	input  wire        xfer_done;              // one pulse per data transfer
	input  wire        xfer_16bit;             // 1 = 16-bit transfer mode
	input  wire        chan_reset;             // channel reset pulse
	output reg         svc_request_q;          // request to be serviced
	output reg         controller_enabled_q;
	output reg  [7:0]  addr_upper_q;           // address lines 23..16
	output reg         terminal_count_q;       // one-cycle pulse on count expiry

	reg  [7:0]  transfer_page_q;
	reg  [15:0] transfer_count_q;
	reg         controller_disable_bit_q;
	reg  [1:0]  transfer_mode_select_q;
	reg  [5:0]  mode_other_q;
	reg         socket_request_mask_q;
	reg         sw_request_q;
	reg  [15:0] count_d;
	reg  [15:0] dec_amt;
	reg  [7:0]  rdata_d;
	wire [3:0]  terminal_count_flags;
	wire        wr_page;
	wire        wr_cnt_lo;
	wire        wr_cnt_hi;
	wire        wr_cmd;
	wire        wr_swreq;
	wire        wr_mode;
	wire        wr_mask;
	wire        wr_mclear;
	wire        rd_status;
	wire        ch_clear;
	wire        active;
	wire        tc_hit;

	// address decode of the write and read strobes
	assign wr_page   = io_wr && (io_addr == `DDMAS_OFS_PAGE);
	assign wr_cnt_lo = io_wr && (io_addr == `DDMAS_OFS_COUNT_LO);
	assign wr_cnt_hi = io_wr && (io_addr == `DDMAS_OFS_COUNT_HI);
	assign wr_cmd    = io_wr && (io_addr == `DDMAS_OFS_STATCMD);
	assign wr_swreq  = io_wr && (io_addr == `DDMAS_OFS_SWREQ);
	assign wr_mode   = io_wr && (io_addr == `DDMAS_OFS_MODE);
	assign wr_mask   = io_wr && (io_addr == `DDMAS_OFS_MASK);
	assign wr_mclear = io_wr && (io_addr == `DDMAS_OFS_MCLEAR);
	assign rd_status = io_rd && (io_addr == `DDMAS_OFS_STATCMD);
	assign ch_clear  = chan_reset || wr_mclear;
	assign active    = !controller_disable_bit_q;

	// count reaches zero on a transfer while enabled
	assign tc_hit = active && xfer_done && (transfer_count_q <= dec_amt);

	// count next value: register write beats a transfer in the same cycle
	always @* begin
		dec_amt = xfer_16bit ? `DDMAS_DEC_16BIT : `DDMAS_DEC_8BIT;
		count_d = transfer_count_q;
		if (active && xfer_done) begin
			if (transfer_count_q <= dec_amt) begin
				count_d = `DDMAS_ZERO16;
			end else begin
				count_d = transfer_count_q - dec_amt;
			end
		end
		if (wr_cnt_lo) begin
			count_d = {transfer_count_q[15:8], io_wdata};
		end
		if (wr_cnt_hi) begin
			count_d = {io_wdata, transfer_count_q[7:0]};
		end
	end

	// programmable registers; master clear restores all of them
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			transfer_page_q          <= `DDMAS_PAGE_RST;
			transfer_count_q         <= `DDMAS_COUNT_RST;
			controller_disable_bit_q <= 1'b0;
			transfer_mode_select_q   <= `DDMAS_XMODE_DEMAND;
			mode_other_q             <= 6'h00;
			socket_request_mask_q    <= `DDMAS_MASK_RST;
			sw_request_q             <= 1'b0;
		end else if (wr_mclear) begin
			transfer_page_q          <= `DDMAS_PAGE_RST;
			transfer_count_q         <= `DDMAS_COUNT_RST;
			controller_disable_bit_q <= 1'b0;
			transfer_mode_select_q   <= `DDMAS_XMODE_DEMAND;
			mode_other_q             <= 6'h00;
			socket_request_mask_q    <= `DDMAS_MASK_RST;
			sw_request_q             <= 1'b0;
		end else begin
			if (wr_page) begin
				transfer_page_q <= io_wdata;
			end
			transfer_count_q <= count_d;
			if (wr_cmd) begin
				controller_disable_bit_q <= io_wdata[`DDMAS_CMD_DIS_BIT];
			end
			if (wr_mode) begin
				transfer_mode_select_q <= io_wdata[`DDMAS_MODE_SEL_HI:`DDMAS_MODE_SEL_LO];
				mode_other_q           <= io_wdata[5:0] & `DDMAS_MODE_RW_MASK;
			end
			if (wr_mask) begin
				socket_request_mask_q <= io_wdata[0];
			end
			// soft requests stay on until the count expires, a channel reset or a master clear
			if (wr_swreq) begin
				sw_request_q <= 1'b1;
			end else if (tc_hit || chan_reset) begin
				sw_request_q <= 1'b0;
			end
		end
	end

	// one sticky terminal count bit per status position, all set together
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_tc
			ddmas_flag u_tc (
				.mclk   (mclk),
				.rst_b  (rst_b),
				.set_i  (tc_hit),
				.clr_i  (rd_status || ch_clear),
				.flag_q (terminal_count_flags[gi])
			);
		end
	endgenerate

	// read mux; reserved and write-only locations read zero
	always @* begin
		rdata_d = `DDMAS_ZERO8;
		case (io_addr)
			`DDMAS_OFS_PAGE:     rdata_d = transfer_page_q;
			`DDMAS_OFS_COUNT_LO: rdata_d = transfer_count_q[7:0];
			`DDMAS_OFS_COUNT_HI: rdata_d = transfer_count_q[15:8];
			`DDMAS_OFS_STATCMD: begin
				// request bits track the raw line, mask not applied
				rdata_d = {card_transfer_request ? `DDMAS_NIBBLE_ONES
				          : `DDMAS_NIBBLE_ZERO, terminal_count_flags};
			end
			`DDMAS_OFS_MODE:     rdata_d = {transfer_mode_select_q, mode_other_q};
			`DDMAS_OFS_MASK:     rdata_d = {7'h00, socket_request_mask_q};
			default:             rdata_d = `DDMAS_ZERO8;
		endcase
	end

	// registered outputs; read data lands one cycle after the strobe
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			io_rdata             <= `DDMAS_ZERO8;
			svc_request_q        <= 1'b0;
			controller_enabled_q <= 1'b0;
			addr_upper_q         <= `DDMAS_ZERO8;
			terminal_count_q     <= 1'b0;
		end else begin
			io_rdata <= io_rd ? rdata_d : `DDMAS_ZERO8;
			// card requests pass only when unmasked; soft ones only in block mode
			svc_request_q <= active &&
				((card_transfer_request && !socket_request_mask_q) ||
				 (sw_request_q &&
				  (transfer_mode_select_q == `DDMAS_XMODE_BLOCK)));
			controller_enabled_q <= active;
			// 16-bit mode drops page bit 0, address bit 16 comes from the word address
			addr_upper_q <= xfer_16bit ? {transfer_page_q[7:1], 1'b0}
			                           : transfer_page_q;
			terminal_count_q <= tc_hit;
		end
	end
endmodule // ddmas_core

// >>> ddmas_core_props.sv
`timescale 1ns/100ps
// passive watcher; read data is judged one cycle after its strobe
module ddmas_core_props (
	input wire       mclk,
	input wire       rst_b,
	input wire [3:0] io_addr,
	input wire       io_wr,
	input wire       io_rd,
	input wire [7:0] io_wdata,
	input wire [7:0] io_rdata,
	input wire       card_transfer_request,
	input wire       xfer_done,
	input wire       xfer_16bit,
	input wire       chan_reset,
	input wire       svc_request_q,
	input wire       controller_enabled_q,
	input wire [7:0] addr_upper_q,
	input wire       terminal_count_q
);
	// status read strobe at the shared offset
	wire st_rd = io_rd && (io_addr == 4'h8);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	AST_RD_IDLE: assert property (!$past(io_rd) |-> io_rdata == 8'h00)
		else $error("read data set outside a read");
	AST_REQ_STAT: assert property (st_rd && $stable(card_transfer_request)
		|=> io_rdata[7:4] == {4{$past(card_transfer_request)}}) else $error("request bits wrong");
	AST_TC_WHOLE: assert property ($past(st_rd) |-> io_rdata[3:0] inside {4'h0, 4'hf})
		else $error("count flags split");
	AST_TC_SEEN: assert property (terminal_count_q ##1 (!st_rd && !chan_reset) [*3]
		##1 st_rd |=> io_rdata[3:0] == 4'hf) else $error("expiry not reported");
	AST_TC_CLR: assert property (st_rd && !xfer_done ##1 !xfer_done ##1 st_rd && !xfer_done
		|=> io_rdata[3:0] == 4'h0) else $error("flags survive a status read");
	AST_CRST: assert property (chan_reset && !xfer_done ##1 !xfer_done ##1 st_rd && !xfer_done
		|=> io_rdata[3:0] == 4'h0) else $error("flags survive channel reset");
	AST_EN: assert property (io_wr && io_addr == 4'h8 ##1 !io_wr
		|=> controller_enabled_q == ~$past(io_wdata[2], 2)) else $error("enable wrong");
	AST_PAGE: assert property (io_wr && io_addr == 4'h2 ##1 (!io_wr && $stable(xfer_16bit)) [*2]
		|-> addr_upper_q == ($past(io_wdata, 2) & {7'h7f, ~xfer_16bit})) else $error("page lines wrong");
endmodule // ddmas_core_props

bind ddmas_core ddmas_core_props u_props (.mclk(mclk), .rst_b(rst_b), .io_addr(io_addr),
	.io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
	.card_transfer_request(card_transfer_request), .xfer_done(xfer_done),
	.xfer_16bit(xfer_16bit), .chan_reset(chan_reset), .svc_request_q(svc_request_q),
	.controller_enabled_q(controller_enabled_q), .addr_upper_q(addr_upper_q),
	.terminal_count_q(terminal_count_q));

// >>> ddmas_card_model.sv
`timescale 1ns/100ps
// card and master side: request level plus one transfer pulse per go
module ddmas_card_model (
	input wire mclk,
	input wire rst_b,
	input wire req_lvl,
	input wire go,
	output reg card_transfer_request,
	output reg xfer_done
);
	// launched on the edge so the core never sees a change in its setup window
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			card_transfer_request <= 1'b0;
			xfer_done <= 1'b0;
		end else begin
			card_transfer_request <= req_lvl;
			xfer_done <= go;
		end
	end
endmodule // ddmas_card_model

// >>> tb_ddmas_core.sv
`timescale 1ns/100ps
module tb_ddmas_core;
	reg        mclk, rst_b, io_wr, io_rd, xfer_16bit, chan_reset, req_lvl, go, seen;
	reg  [3:0] io_addr;
	reg  [7:0] io_wdata;
	wire [7:0] io_rdata, addr_upper_q;
	wire       card_transfer_request, xfer_done, svc_q, en_q, tc_q;
	integer    miscompares, cmp_count, i;
	ddmas_core uut (.mclk(mclk), .rst_b(rst_b), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
		.io_wdata(io_wdata), .io_rdata(io_rdata), .card_transfer_request(card_transfer_request),
		.xfer_done(xfer_done), .xfer_16bit(xfer_16bit), .chan_reset(chan_reset),
		.svc_request_q(svc_q), .controller_enabled_q(en_q), .addr_upper_q(addr_upper_q),
		.terminal_count_q(tc_q));
	ddmas_card_model card (.mclk(mclk), .rst_b(rst_b), .req_lvl(req_lvl), .go(go),
		.card_transfer_request(card_transfer_request), .xfer_done(xfer_done));
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	task end_sim; begin
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	end endtask
	task chk(input [15:0] g, input [15:0] e); begin
		cmp_count = cmp_count + 1;
		if (g !== e) begin
			miscompares = miscompares + 1;
			$display("ERROR at %0t got %h expected %h", $time, g, e);
		end
	end endtask
	// inputs always move 2 ns after a rising edge
	task cyc(input integer n); begin
		repeat (n) @(posedge mclk);
		#2;
	end endtask
	task wr(input [3:0] a, input [7:0] d); begin
		cyc(1);
		io_addr = a;
		io_wdata = d;
		io_wr = 1'b1;
		cyc(1);
		io_wr = 1'b0;
	end endtask
	// read data stands only in the cycle after the strobe, so look there
	task rd(input [3:0] a, input [7:0] e); begin
		cyc(1);
		io_addr = a;
		io_rd = 1'b1;
		cyc(1);
		io_rd = 1'b0;
		chk({8'h00, io_rdata}, {8'h00, e});
	end endtask
	task xfer(input m16, input etc); begin
		xfer_16bit = m16;
		seen = 1'b0;
		cyc(1);
		go = 1'b1;
		cyc(1);
		go = 1'b0;
		for (i = 0; i < 4; i = i + 1) begin
			cyc(1);
			if (tc_q === 1'b1) seen = 1'b1;
		end
		chk({15'h0, seen}, {15'h0, etc});
	end endtask
	initial begin
		{rst_b, io_wr, io_rd, xfer_16bit, chan_reset, req_lvl, go, seen} = 8'h00;
		io_addr = 4'h0;
		io_wdata = 8'h00;
		miscompares = 0;
		cmp_count = 0;
		cyc(16);
		rst_b = 1'b1;
		rd(4'h2, 8'h00);
		rd(4'h4, 8'h00);
		rd(4'h8, 8'h00);
		wr(4'h2, 8'ha5);
		rd(4'h2, 8'ha5);
		chk({8'h00, addr_upper_q}, 16'h00a5);
		xfer_16bit = 1'b1;
		cyc(2);
		chk({8'h00, addr_upper_q}, 16'h00a4);
		$display("test page done");
		// card request raised while the mask is still set from reset
		req_lvl = 1'b1;
		wr(4'h4, 8'h05);
		wr(4'h5, 8'h00);
		xfer(1'b0, 1'b0);
		xfer(1'b0, 1'b0);
		rd(4'h4, 8'h03);
		xfer(1'b1, 1'b0);
		rd(4'h4, 8'h01);
		xfer(1'b1, 1'b1);
		rd(4'h8, 8'hff);
		rd(4'h8, 8'hf0);
		wr(4'h4, 8'h01);
		xfer(1'b0, 1'b1);
		cyc(1);
		chan_reset = 1'b1;
		cyc(1);
		chan_reset = 1'b0;
		rd(4'h8, 8'hf0);
		$display("test count done");
		wr(4'h8, 8'h04);
		cyc(1);
		chk({15'h0, en_q}, 16'h0000);
		wr(4'h4, 8'h02);
		xfer(1'b0, 1'b0);
		rd(4'h4, 8'h02);
		wr(4'h8, 8'hfb);
		cyc(1);
		chk({15'h0, en_q}, 16'h0001);
		rd(4'h8, 8'hf0);
		$display("test command done");
		chk({15'h0, svc_q}, 16'h0000);
		wr(4'hf, 8'h00);
		cyc(1);
		chk({15'h0, svc_q}, 16'h0001);
		req_lvl = 1'b0;
		wr(4'hb, 8'h80);
		wr(4'h9, 8'h5a);
		cyc(1);
		chk({15'h0, svc_q}, 16'h0001);
		wr(4'hb, 8'h40);
		cyc(1);
		chk({15'h0, svc_q}, 16'h0000);
		rd(4'h9, 8'h00);
		$display("test requests done");
		end_sim;
	end
endmodule // tb_ddmas_core
